// >>> hdl/cmp_pkg.sv
// ****************************************************************
// shared types and constants
// ****************************************************************
package cmp_pkg;

    // clock and evaluation tick
    localparam int CLK_MHZ      = 100;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
    localparam int NUM_TIMERS   = 32;

    // base ticks per delay unit (one tick is one millisecond)
    localparam logic [16:0] UNIT_MS_TICKS  = 17'h00001;
    localparam logic [16:0] UNIT_S_TICKS   = 17'h003E8;
    localparam logic [16:0] UNIT_MIN_TICKS = 17'h0EA60;

    // time unit selection
    localparam logic [1:0] SCALE_MS  = 2'h0;
    localparam logic [1:0] SCALE_S   = 2'h1;
    localparam logic [1:0] SCALE_MIN = 2'h2;

    // fixed bases in raw value units (mHz, 0.1 deg, 0.001, 0.1 C, 0.1 %)
    localparam logic [23:0] BASE_FREQ  = 24'h0003E8;
    localparam logic [23:0] BASE_ANGLE = 24'h000E10;
    localparam logic [23:0] BASE_PF    = 24'h0003E8;
    localparam logic [23:0] BASE_RTD   = 24'h0003E8;
    localparam logic [23:0] BASE_HARM  = 24'h0003E8;

    // per-unit and percent scaling (milli-pu, 0.1 percent)
    localparam logic signed [63:0] MILLI   = 64'sh3E8;
    localparam logic signed [63:0] MICRO   = 64'shF4240;

    // measured quantity kinds
    typedef enum logic [3:0] {
        QTY_DCMA  = 4'h0, QTY_FREQ  = 4'h1, QTY_ANGLE = 4'h2,
        QTY_PF    = 4'h3, QTY_RTD   = 4'h4, QTY_SRC_I = 4'h5,
        QTY_SRC_P = 4'h6, QTY_SRC_V = 4'h7, QTY_DIFF  = 4'h8,
        QTY_HARM  = 4'h9, QTY_RESTR = 4'hA
    } qty_t;

    // one measured value with its own base
    typedef struct packed {
        logic               on;
        qty_t               qty;
        logic signed [23:0] value;
        logic        [23:0] base;
    } meas_t;

    // comparator settings
    typedef struct packed {
        logic               sign_handling_select;   // 1: magnitude
        logic               comparison_kind_select; // 1: rate of change
        logic               trip_side_select;       // 1: pick below
        logic signed [19:0] operate_level;          // milli-pu
        logic        [9:0]  dropout_band;           // 0.1 percent
        logic        [1:0]  window_time_scale;
        logic        [15:0] window_length;
        logic        [15:0] output_assert_delay;    // ms
        logic        [15:0] output_release_delay;   // ms
    } cmp_cfg_t;

    // delay timer settings
    typedef struct packed {
        logic [1:0]  unit_select;
        logic [15:0] assert_delay;
        logic [15:0] release_delay;
    } timer_cfg_t;

    // base ticks for one unit of the selected scale
    function automatic logic [16:0] unit_ticks(input logic [1:0] sc);
        unit_ticks = (sc == SCALE_S)   ? UNIT_S_TICKS :
                     (sc == SCALE_MIN) ? UNIT_MIN_TICKS : UNIT_MS_TICKS;
    endfunction

endpackage

// >>> hdl/delay_timer.sv
`timescale 1ns/100ps
// ****************************************************************
// assert / release delay timer
// ****************************************************************
module delay_timer (
    input  wire logic        ref_clk_i,       // system clock
    input  wire logic        srst_i,          // sync reset
    input  wire logic        tick_i,          // evaluation tick
    input  wire logic [16:0] unit_ticks_i,    // ticks per unit
    input  wire logic [15:0] assert_delay_i,  // units
    input  wire logic [15:0] release_delay_i, // units
    input  wire logic        in_i,            // operand in
    output logic             out_o            // delayed operand
);
    import cmp_pkg::*;

    // all state of the timer
    typedef struct packed {
        logic        out;
        logic [16:0] unit_cnt;
        logic [15:0] delay_cnt;
    } tmr_state_t;

    tmr_state_t st_r;   // registered state
    tmr_state_t st_nxt; // next state
    logic [15:0] delay; // delay toward the input level

    // next state, evaluated on each tick
    always_comb begin
        st_nxt = st_r;
        delay  = in_i ? assert_delay_i : release_delay_i;
        if (tick_i) begin
            if (in_i == st_r.out) begin
                // input agrees: restart timing
                st_nxt.unit_cnt  = 17'h0;
                st_nxt.delay_cnt = 16'h0;
            end else if (delay == 16'h0) begin
                st_nxt.out = in_i;
            end else if (st_r.unit_cnt + 17'h1 >= unit_ticks_i) begin
                // one unit elapsed
                st_nxt.unit_cnt  = 17'h0;
                st_nxt.delay_cnt = st_r.delay_cnt + 16'h1;
                if (st_r.delay_cnt + 16'h1 >= delay) begin
                    st_nxt.out       = in_i;
                    st_nxt.delay_cnt = 16'h0;
                end
            end else begin
                st_nxt.unit_cnt = st_r.unit_cnt + 17'h1;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_o = st_r.out;

endmodule // delay_timer

// >>> hdl/analog_threshold_comparator.sv
`timescale 1ns/100ps
// Operation
// - thirty-two identical delay timers for logic
// - each timer selects its delay unit
// - assert after input true for pickup delay
// - release after input false for dropout delay
// - first input, zero when not selected
// - subtract second input, zero when off
// - no inputs selected means no pickup
// - mismatched input types disable the comparator
// - signed difference or its magnitude
// - compare level or change over interval
// - pick above when signal exceeds level
// - pick below when signal under level
// - signed compare of signal and level
// - hysteresis band is percent of level
// - level in per-unit with fixed bases
// - transducer base is larger range maximum
// - source base is larger nominal value
// - transformer base is larger reference current
// - interval settings used only in rate mode
// - output asserted after the pickup delay
// - output released after the reset delay
// - evaluate at least four times per cycle
module analog_threshold_comparator #(
    parameter int TICK_CYCLES_P = cmp_pkg::TICK_CYCLES // cycles per tick
) (
    input  wire logic                 ref_clk_i,      // system clock
    input  wire logic                 srst_i,         // sync reset
    input  cmp_pkg::meas_t            pos_meas_i,     // first input
    input  cmp_pkg::meas_t            neg_meas_i,     // second input
    input  cmp_pkg::cmp_cfg_t         cmp_cfg_i,      // settings
    input  cmp_pkg::timer_cfg_t [31:0] timer_cfg_i,   // timer settings
    input  wire logic [31:0]          timer_in_i,     // timer operands
    output logic [31:0]               timer_out_o,    // timer results
    output logic                      element_pkp_o,  // picked up
    output logic                      element_op_o,   // delayed output
    output logic                      eval_tick_o     // evaluation tick
);
    import cmp_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************

    // comparator pickup state
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_PICKED = 2'b10
    } pick_state_t;

    // all state of the module
    typedef struct packed {
        logic [16:0]        tick_cnt;  // divider
        logic               tick;      // tick pulse
        pick_state_t        pick;      // hysteresis state
        logic [16:0]        win_unit;  // interval unit count
        logic [15:0]        win_cnt;   // interval length count
        logic signed [27:0] snap;      // value at interval start
        logic signed [27:0] delta;     // change over last interval
        logic               delta_ok;  // one interval completed
    } top_state_t;

    top_state_t st_r;   // registered state
    top_state_t st_nxt; // next state

    // ****************************************************************
    // operating signal
    // ****************************************************************

    logic signed [27:0] pos_val;   // first value or zero
    logic signed [27:0] neg_val;   // second value or zero
    logic signed [27:0] diff_val;  // difference
    logic signed [27:0] op_val;    // after sign handling
    logic signed [27:0] eval_val;  // level or change
    logic               any_sel;   // at least one input
    logic               type_ok;   // inputs of one kind
    logic               enabled;   // comparator may operate
    qty_t               kind;      // quantity kind in use
    logic        [23:0] base;      // per-unit base
    logic        [16:0] tick_max;  // divider terminal count

    // input selection and difference
    always_comb begin
        pos_val = pos_meas_i.on ? 28'(pos_meas_i.value) : 28'sh0;
        neg_val = neg_meas_i.on ? 28'(neg_meas_i.value) : 28'sh0;
        diff_val = pos_val - neg_val;
        if (cmp_cfg_i.sign_handling_select && diff_val < 0) begin
            op_val = -diff_val;
        end else begin
            op_val = diff_val;
        end
    end

    // enable conditions
    always_comb begin
        any_sel = pos_meas_i.on | neg_meas_i.on;
        type_ok = !(pos_meas_i.on && neg_meas_i.on) ||
                  (pos_meas_i.qty == neg_meas_i.qty);
        enabled = any_sel && type_ok;
        kind    = pos_meas_i.on ? pos_meas_i.qty : neg_meas_i.qty;
    end

    // per-unit base selection
    always_comb begin
        base = 24'h1;
        unique case (kind)
            QTY_FREQ:  base = BASE_FREQ;
            QTY_ANGLE: base = BASE_ANGLE;
            QTY_PF:    base = BASE_PF;
            QTY_RTD:   base = BASE_RTD;
            QTY_HARM:  base = BASE_HARM;
            QTY_DCMA, QTY_SRC_I, QTY_SRC_V, QTY_SRC_P,
            QTY_DIFF, QTY_RESTR: begin
                // larger base of the selected inputs
                base = 24'h0;
                if (pos_meas_i.on) begin
                    base = pos_meas_i.base;
                end
                if (neg_meas_i.on && neg_meas_i.base > base) begin
                    base = neg_meas_i.base;
                end
                if (base == 24'h0) begin
                    base = 24'h1; // guard against an unset base
                end
            end
            default: base = 24'h1; // unused kind codes
        endcase
    end

    // level or rate of change
    always_comb begin
        if (cmp_cfg_i.comparison_kind_select) begin
            eval_val = st_r.delta;
        end else begin
            eval_val = op_val;
        end
    end

    // ****************************************************************
    // threshold arithmetic
    // ****************************************************************

    logic signed [63:0] sig64;   // signal scaled to micro units
    logic signed [63:0] lvl64;   // operate level, milli-pu
    logic signed [63:0] base64;  // base, widened
    logic signed [63:0] band64;  // band setting, widened
    logic signed [63:0] thr;     // threshold in the same units
    logic signed [63:0] hyst;    // band width in the same units
    logic               pick_hi; // pick condition
    logic               drop_hi; // drop condition

    // scaled signed comparison
    always_comb begin
        sig64  = 64'(eval_val) * MICRO;
        lvl64  = 64'(cmp_cfg_i.operate_level);
        base64 = $signed({40'h0, base});
        band64 = $signed({54'h0, cmp_cfg_i.dropout_band});
        thr    = lvl64 * base64 * MILLI;
        if (lvl64 < 0) begin
            hyst = -lvl64 * base64 * band64;
        end else begin
            hyst = lvl64 * base64 * band64;
        end
        if (cmp_cfg_i.trip_side_select) begin
            pick_hi = sig64 < thr;
            drop_hi = sig64 > thr + hyst;
        end else begin
            pick_hi = sig64 > thr;
            drop_hi = sig64 < thr - hyst;
        end
    end

    // ****************************************************************
    // divider, interval and pickup state
    // ****************************************************************

    logic [16:0] win_units; // ticks per interval unit
    logic [15:0] win_len;   // interval length, at least one

    // interval settings
    always_comb begin
        win_units = unit_ticks(cmp_cfg_i.window_time_scale);
        if (cmp_cfg_i.window_length == 16'h0) begin
            win_len = 16'h1;
        end else begin
            win_len = cmp_cfg_i.window_length;
        end
        tick_max = 17'(TICK_CYCLES_P - 1);
    end

    // next state
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        // tick divider, one pulse per millisecond
        if (st_r.tick_cnt >= tick_max) begin
            st_nxt.tick_cnt = 17'h0;
            st_nxt.tick     = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 17'h1;
        end
        if (st_r.tick) begin
            // rate of change window, only in rate mode
            if (!cmp_cfg_i.comparison_kind_select) begin
                st_nxt.win_unit = 17'h0;
                st_nxt.win_cnt  = 16'h0;
                st_nxt.snap     = op_val;
                st_nxt.delta    = 28'sh0;
                st_nxt.delta_ok = 1'b0;
            end else if (st_r.win_unit + 17'h1 >= win_units) begin
                st_nxt.win_unit = 17'h0;
                if (st_r.win_cnt + 16'h1 >= win_len) begin
                    // interval closed: latch change
                    st_nxt.win_cnt  = 16'h0;
                    st_nxt.delta    = op_val - st_r.snap;
                    st_nxt.snap     = op_val;
                    st_nxt.delta_ok = 1'b1;
                end else begin
                    st_nxt.win_cnt = st_r.win_cnt + 16'h1;
                end
            end else begin
                st_nxt.win_unit = st_r.win_unit + 17'h1;
            end
            // pickup with hysteresis
            unique case (st_r.pick)
                ST_IDLE: begin
                    if (pick_hi) begin
                        st_nxt.pick = ST_PICKED;
                    end
                end
                ST_PICKED: begin
                    if (drop_hi) begin
                        st_nxt.pick = ST_IDLE;
                    end
                end
                default: st_nxt.pick = ST_IDLE;  // illegal code
            endcase
            // no valid inputs or no full interval yet
            if (!enabled ||
                (cmp_cfg_i.comparison_kind_select && !st_r.delta_ok)) begin
                st_nxt.pick = ST_IDLE;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r      <= '0;
            st_r.pick <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // output delay of the comparator
    // ****************************************************************

    logic pick_q; // picked state as a bit

    assign pick_q = (st_r.pick == ST_PICKED);

    // pickup and reset delay in milliseconds
    delay_timer cmp_delay_u (
        .ref_clk_i       (ref_clk_i),
        .srst_i          (srst_i),
        .tick_i          (st_r.tick),
        .unit_ticks_i    (UNIT_MS_TICKS),
        .assert_delay_i  (cmp_cfg_i.output_assert_delay),
        .release_delay_i (cmp_cfg_i.output_release_delay),
        .in_i            (pick_q),
        .out_o           (element_op_o)
    );

    // ****************************************************************
    // timer bank for the logic engine
    // ****************************************************************

    // one timer per operand slot
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
        delay_timer timer_u (
            .ref_clk_i       (ref_clk_i),
            .srst_i          (srst_i),
            .tick_i          (st_r.tick),
            .unit_ticks_i    (unit_ticks(timer_cfg_i[g].unit_select)),
            .assert_delay_i  (timer_cfg_i[g].assert_delay),
            .release_delay_i (timer_cfg_i[g].release_delay),
            .in_i            (timer_in_i[g]),
            .out_o           (timer_out_o[g])
        );
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    assign element_pkp_o = pick_q;
    assign eval_tick_o   = st_r.tick;

endmodule // analog_threshold_comparator

// >>> tb/atc_properties.sv
`timescale 1ns/100ps
// ****************************************************************
// port checker for the comparator top
// ****************************************************************
module atc_properties
    import cmp_pkg::*;
#(
    parameter int TICK_CYCLES_P = 10 // cycles per tick
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  srst_i,
    input  cmp_pkg::meas_t             pos_meas_i,
    input  cmp_pkg::meas_t             neg_meas_i,
    input  cmp_pkg::cmp_cfg_t          cmp_cfg_i,
    input  cmp_pkg::timer_cfg_t [31:0] timer_cfg_i,
    input  wire logic [31:0]           timer_in_i,
    input  wire logic [31:0]           timer_out_o,
    input  wire logic                  element_pkp_o,
    input  wire logic                  element_op_o,
    input  wire logic                  eval_tick_o
);
    typedef struct packed {
        logic [31:0] gap;  // cycles since last tick
        logic        seen; // a tick has passed since reset
    } gap_state_t;
    gap_state_t st_r;      // helper state
    gap_state_t st_nxt;    // its next value
    // count cycles between ticks
    always_comb begin
        st_nxt = st_r;
        st_nxt.gap = eval_tick_o ? 32'h0 : st_r.gap + 32'h1;
        st_nxt.seen = st_r.seen | eval_tick_o;
        if (srst_i) begin
            st_nxt = '0;
        end
    end
    // register the helper state
    always_ff @(posedge ref_clk_i) begin
        st_r <= st_nxt;
    end
    default clocking dcb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    a_tick_single: assert property (
        eval_tick_o |=> !eval_tick_o) else $error("tick pulse too long");
    a_tick_spacing: assert property (
        eval_tick_o && st_r.seen |-> st_r.gap == 32'(TICK_CYCLES_P - 1))
        else $error("tick spacing wrong");
    a_pkp_on_tick: assert property (
        $changed(element_pkp_o) |-> $past(eval_tick_o)) else $error("pickup moved off tick");
    a_idle_inputs: assert property (
        eval_tick_o && !pos_meas_i.on && !neg_meas_i.on |=> !element_pkp_o)
        else $error("pickup with no input selected");
    a_kind_clash: assert property (
        eval_tick_o && pos_meas_i.on && neg_meas_i.on && pos_meas_i.qty != neg_meas_i.qty
        |=> !element_pkp_o) else $error("pickup with mixed input kinds");
    a_op_rise_cause: assert property (
        $rose(element_op_o) |-> $past(element_pkp_o)) else $error("output rose without pickup");
    a_op_fall_cause: assert property (
        $fell(element_op_o) |-> !$past(element_pkp_o)) else $error("output fell during pickup");
    a_timer_zero_set: assert property (
        eval_tick_o && timer_cfg_i[0].assert_delay == 16'h0000 && timer_in_i[0]
        |=> timer_out_o[0]) else $error("zero delay timer did not set");
    a_timer_zero_clr: assert property (
        eval_tick_o && timer_cfg_i[0].release_delay == 16'h0000 && !timer_in_i[0]
        |=> !timer_out_o[0]) else $error("zero delay timer did not clear");
    a_timer_on_tick: assert property (
        $changed(timer_out_o) |-> $past(eval_tick_o)) else $error("timer moved off tick");
endmodule // atc_properties

bind analog_threshold_comparator atc_properties #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_props (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .pos_meas_i(pos_meas_i), .neg_meas_i(neg_meas_i),
    .cmp_cfg_i(cmp_cfg_i), .timer_cfg_i(timer_cfg_i), .timer_in_i(timer_in_i),
    .timer_out_o(timer_out_o), .element_pkp_o(element_pkp_o), .element_op_o(element_op_o),
    .eval_tick_o(eval_tick_o));

// >>> tb/meas_src.sv
`timescale 1ns/100ps
// ****************************************************************
// measurement source for one comparator input
// ****************************************************************
module meas_src (
    input  wire logic        ref_clk_i, // system clock
    input  cmp_pkg::meas_t   set_i,     // wanted value
    input  wire logic [11:0] v_base_i,  // voltage base
    input  wire logic [11:0] i_base_i,  // current base
    output cmp_pkg::meas_t   meas_o     // value as measured
);
    import cmp_pkg::*;
    // refresh every clock; a power value carries the v times i base
    always_ff @(posedge ref_clk_i) begin
        meas_o <= set_i;
        if (set_i.qty == QTY_SRC_P) begin
            meas_o.base <= 24'(v_base_i) * 24'(i_base_i);
        end
    end
endmodule // meas_src

// >>> tb/tb_top.sv
`timescale 1ns/100ps
// ****************************************************************
// comparator and timer bank bench
// ****************************************************************
module tb_top;
    import cmp_pkg::*;
    localparam int TICK_P = 10;           // short tick for simulation
    logic               ref_clk = 1'b0;   // 100 MHz clock
    logic               srst;             // sync reset
    meas_t              pos_s, neg_s;     // wanted input values
    meas_t              pos_m, neg_m;     // measured input values
    logic [11:0]        pvb, pib, nvb, nib; // power base parts
    cmp_cfg_t           cfg;              // comparator settings
    timer_cfg_t [31:0]  tcfg;             // timer settings
    logic [31:0]        tin, tout;        // timer operands
    logic               pkp, op, tick;    // comparator outputs
    int                 errors, checked;  // counts
    always #5 ref_clk = ~ref_clk;
    meas_src u_pos (.ref_clk_i(ref_clk), .set_i(pos_s), .v_base_i(pvb), .i_base_i(pib),
                    .meas_o(pos_m));
    meas_src u_neg (.ref_clk_i(ref_clk), .set_i(neg_s), .v_base_i(nvb), .i_base_i(nib),
                    .meas_o(neg_m));
    analog_threshold_comparator #(.TICK_CYCLES_P(TICK_P)) dut (
        .ref_clk_i(ref_clk), .srst_i(srst), .pos_meas_i(pos_m), .neg_meas_i(neg_m),
        .cmp_cfg_i(cfg), .timer_cfg_i(tcfg), .timer_in_i(tin), .timer_out_o(tout),
        .element_pkp_o(pkp), .element_op_o(op), .eval_tick_o(tick));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // wait for n ticks to land, ending on the falling edge after each
    task automatic settle(input int n);
        repeat (n) begin
            do @(negedge ref_clk); while (tick !== 1'b1);
            @(negedge ref_clk);
        end
    endtask
    // drive both inputs off the sampling edge; unset fields are zero or off, except the second kind, which is QTY_FREQ
    task automatic setm(input logic po, input qty_t pq, input int pv, input int pb = 0,
                        input logic no = 1'b0, input qty_t nq = QTY_FREQ,
                        input int nv = 0, input int nb = 0);
        @(negedge ref_clk);
        pos_s = '{po, pq, 24'(pv), 24'(pb)};
        neg_s = '{no, nq, 24'(nv), 24'(nb)};
    endtask
    // drive the inputs, then check pickup after the next tick
    task automatic mchk(input logic e, input logic po, input qty_t pq, input int pv,
                        input int pb = 0, input logic no = 1'b0, input qty_t nq = QTY_FREQ,
                        input int nv = 0, input int nb = 0);
        setm(po, pq, pv, pb, no, nq, nv, nb);
        settle(1);
        chk(32'(pkp), 32'(e));
    endtask
    // comparator settings: direction, magnitude, level, band
    task automatic setc(input logic below, input logic mag, input int lvl, input int band);
        @(negedge ref_clk);
        cfg = '0;
        cfg.trip_side_select = below;
        cfg.sign_handling_select = mag;
        cfg.operate_level = 20'(lvl);
        cfg.dropout_band = 10'(band);
    endtask
    task automatic do_reset();
        @(negedge ref_clk);
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
    endtask
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_above();
        setc(1'b0, 1'b0, 1000, 100);
        mchk(1'b1, 1, QTY_FREQ, 1500);
        mchk(1'b1, 1, QTY_FREQ, 950);
        mchk(1'b0, 1, QTY_FREQ, 850);
        mchk(1'b0, 1, QTY_ANGLE, 3240);
        mchk(1'b1, 1, QTY_ANGLE, 3960);
    endtask
    task automatic t_below();
        setc(1'b1, 1'b0, -500, 100);
        mchk(1'b1, 1, QTY_FREQ, -700);
        mchk(1'b1, 1, QTY_FREQ, -480);
        mchk(1'b0, 1, QTY_FREQ, -400);
    endtask
    task automatic t_inputs();
        setc(1'b0, 1'b0, 1000, 0);
        mchk(1'b0, 1, QTY_FREQ, 300, 0, 1, QTY_FREQ, 1500);
        setc(1'b0, 1'b1, 1000, 0);
        settle(1);
        chk(32'(pkp), 32'h1);
        setc(1'b0, 1'b0, 1000, 0);
        mchk(1'b0, 1, QTY_FREQ, 300);
        mchk(1'b1, 0, QTY_FREQ, 300, 0, 1, QTY_FREQ, -1500);
    endtask
    task automatic t_refuse();
        setc(1'b0, 1'b0, -1000, 0);
        mchk(1'b0, 0, QTY_FREQ, 0);
        mchk(1'b0, 1, QTY_FREQ, 0, 0, 1, QTY_ANGLE);
        mchk(1'b1, 1, QTY_FREQ, 0, 0, 1);
    endtask
    task automatic t_bases();
        setc(1'b0, 1'b0, 400, 0);
        mchk(1'b0, 1, QTY_DCMA, 600, 1000, 1, QTY_DCMA, 0, 2000);
        mchk(1'b1, 1, QTY_DCMA, 1000, 1000, 1, QTY_DCMA, 0, 2000);
        {pvb, pib, nvb, nib} = {12'h064, 12'h00A, 12'h0C8, 12'h00A};
        mchk(1'b0, 1, QTY_SRC_P, 600, 0, 1, QTY_SRC_P);
        mchk(1'b1, 1, QTY_SRC_P, 600);
    endtask
    task automatic t_rate();
        setc(1'b0, 1'b0, 1000, 0);
        setm(1, QTY_FREQ, 5000);
        cfg.comparison_kind_select = 1'b1;
        cfg.window_time_scale = SCALE_MS;
        cfg.window_length = 16'h0002;
        settle(8);
        chk(32'(pkp), 32'h0);
        setm(1, QTY_FREQ, 8000);
        for (int i = 0; i < 6 && pkp !== 1'b1; i++) settle(1);
        chk(32'(pkp), 32'h1);
    endtask
    task automatic t_delay();
        setc(1'b0, 1'b0, 1000, 0);
        cfg.output_assert_delay = 16'h0003;
        cfg.output_release_delay = 16'h0002;
        setm(1, QTY_FREQ, 0);
        settle(4);
        setm(1, QTY_FREQ, 1500);
        settle(3);
        chk(32'(op), 32'h0);
        settle(2);
        chk(32'(op), 32'h1);
        setm(1, QTY_FREQ, 0);
        settle(2);
        chk({pkp, op}, 32'h1);
        settle(2);
        chk(32'(op), 32'h0);
        setc(1'b0, 1'b0, 1000, 0);
        setm(1, QTY_FREQ, 1500);
        settle(1);
        chk({pkp, op}, 32'h2);
        settle(1);
        chk(32'(op), 32'h1);
        do_reset();
        chk({pkp, op}, 32'h0);
    endtask
    task automatic t_timers();
        @(negedge ref_clk);
        tcfg = '0;
        tin = 32'hA5A55A5A;
        settle(2);
        chk(tout, 32'hA5A55A5A);
        tin = ~tin;
        settle(1);
        chk(tout, 32'h5A5AA5A5);
        tin = 32'h0;
        settle(1);
        tcfg[1] = '{SCALE_S, 16'h0001, 16'h0000};
        tcfg[2] = '{SCALE_MS, 16'h0003, 16'h0003};
        tin = 32'h6;
        settle(2);
        chk(tout, 32'h0);
        settle(2);
        chk(tout, 32'h4);
        settle(998);
        chk(tout, 32'h6);
        tin = 32'h0;
        settle(2);
        chk(tout, 32'h4);
        settle(2);
        chk(tout, 32'h0);
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        errors = 0;
        checked = 0;
        srst = 1'b1;
        {pos_s, neg_s, pvb, pib, nvb, nib, cfg, tcfg, tin} = '0;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        t_above();
        t_below();
        t_inputs();
        t_refuse();
        t_bases();
        t_rate();
        t_delay();
        t_timers();
        wrap_up();
    end
    initial begin
        #400000;
        errors++;
        wrap_up();
    end
endmodule // tb_top
